// ===== include/bit_ops_pkg.sv
// Package: encodings, field layout and carriers for the bit-op decoder
`default_nettype none
package bit_ops_pkg;
	localparam int          INSN_W      = 14;
	localparam int          ADDR_W      = 7;
	localparam int          BIT_W       = 3;
	localparam int          DATA_W      = 8;
	localparam int          OPC_MSB     = 13;
	localparam int          OPC_LSB     = 10;
	localparam int          BIDX_MSB    = 9;
	localparam int          BIDX_LSB    = 7;
	localparam int          FADR_MSB    = 6;
	localparam int          FADR_LSB    = 0;
	localparam logic [3:0]  OPC_SET     = 4'h5;
	localparam logic [3:0]  OPC_SKIP_CLR = 4'h6;
	localparam logic [3:0]  OPC_SKIP_SET = 4'h7;
	localparam logic [13:0] NOP_WORD    = 14'h0000;
	localparam int          SKIP_CYCLES = 2;

	typedef enum logic [0:0] {
		ST_RUN  = 1'b0,
		ST_NOP  = 1'b1
	} exec_state_t;

	typedef struct packed {
		logic              en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} file_wr_t;
endpackage : bit_ops_pkg
`default_nettype wire

// ===== hw/bit_ops_decode.sv
// Decode and execute of bit test/skip and bit set instructions
`default_nettype none
module bit_ops_decode
	import bit_ops_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              SRST,
	input  wire logic              INSN_VALID,
	input  wire logic [INSN_W-1:0] INSN,
	input  wire logic [DATA_W-1:0] FILE_RDATA,
	output logic      [ADDR_W-1:0] FILE_RADDR,
	output file_wr_t               FILE_WR,
	output logic                   SKIP_TAKEN,
	output logic                   NOP_EXEC,
	output logic                   DECODE_HIT,
	output logic                   FLAGS_WE
);

	////////////////////////////////////////////////////////////////////
	exec_state_t            state;
	exec_state_t            next_state;
	logic [1:0]             span;
	wire logic [1:0]        next_span;
	wire file_wr_t          next_wr;
	wire logic              next_skip;
	wire logic [3:0]        opc;
	wire logic [BIT_W-1:0]  bidx;
	wire logic [ADDR_W-1:0] fadr;
	wire logic              live;
	wire logic              is_bsc;
	wire logic              is_bss;
	wire logic              is_set;
	wire logic              is_test;
	wire logic              is_other;
	wire logic              fwd_hit;
	wire logic [DATA_W-1:0] rdv;
	wire logic [DATA_W-1:0] bmask;
	wire logic              tbit;
	wire logic              skip_clr;
	wire logic              skip_set;
	wire logic              skip;
	wire logic [DATA_W-1:0] setv;

	// Word fields
	assign opc      = INSN[OPC_MSB:OPC_LSB];
	assign bidx     = INSN[BIDX_MSB:BIDX_LSB];
	assign fadr     = INSN[FADR_MSB:FADR_LSB];

	// Squash cycle ignores the prefetched word
	assign live     = INSN_VALID && state == ST_RUN;
	assign is_bsc   = live && opc == OPC_SKIP_CLR;
	assign is_bss   = live && opc == OPC_SKIP_SET;
	assign is_set   = live && opc == OPC_SET;
	assign is_test  = is_bsc || is_bss;
	assign is_other = live && !is_test && !is_set;

	// Pending write lands next edge; forward it to a same-register follower
	assign fwd_hit  = FILE_WR.en && FILE_WR.addr == fadr;
	assign rdv      = fwd_hit ? FILE_WR.data : FILE_RDATA;

	// One select line per bit of the file word
	for (genvar i = 0; i < DATA_W; i++) begin : g_bit
		assign bmask[i] = bidx == BIT_W'(i);
	end

	assign tbit     = |(rdv & bmask);
	assign skip_clr = is_bsc && !tbit;
	assign skip_set = is_bss && tbit;
	assign skip     = skip_clr || skip_set;
	assign setv     = rdv | bmask;

	// Read port is combinational so the test sees the current word
	assign FILE_RADDR = fadr;
	assign DECODE_HIT = is_bsc || is_bss || is_set;
	// No flag ever changes for these instructions
	assign FLAGS_WE   = 1'b0;

	always_comb begin
		case (state)
			ST_RUN:  next_state = skip ? ST_NOP : ST_RUN;
			ST_NOP:  next_state = ST_RUN;
			default: next_state = ST_RUN;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	assign next_wr   = '{en: is_set, addr: fadr, data: setv};
	assign next_skip = skip;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			state <= ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			FILE_WR <= '0;
		end else begin
			FILE_WR <= next_wr;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			SKIP_TAKEN <= 1'b0;
		end else begin
			SKIP_TAKEN <= next_skip;
		end
	end

	// Separate flop: fetch timing and squash may later be split apart
	always_ff @(posedge CLK) begin
		if (SRST) begin
			NOP_EXEC <= 1'b0;
		end else begin
			NOP_EXEC <= next_skip;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Cycles used by the current test word; read only by the checks
	assign next_span = (state == ST_NOP) ? span + 2'h1 : {1'b0, is_test};

	always_ff @(posedge CLK) begin
		if (SRST) begin
			span <= 2'h0;
		end else begin
			span <= next_span;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	a_clr_skip: assert property (
		is_bsc && !rdv[bidx] |=> SKIP_TAKEN)
		else $error("skip-if-clear missed");

	a_set_skip: assert property (
		is_bss && rdv[bidx] |=> SKIP_TAKEN)
		else $error("skip-if-set missed");

	a_no_skip: assert property (
		(is_bss && !rdv[bidx]) || (is_bsc && rdv[bidx]) |=> !SKIP_TAKEN)
		else $error("spurious skip");

	// The squashed word must neither decode nor write a cycle later
	a_prefetch_drop: assert property (
		skip |=> NOP_EXEC && !DECODE_HIT ##1 !FILE_WR.en)
		else $error("prefetched word not discarded");

	a_squash_quiet: assert property (
		NOP_EXEC |-> !DECODE_HIT && !skip && state == ST_NOP)
		else $error("word decoded in squash cycle");

	a_nop_state: assert property (
		state == ST_NOP |-> NOP_EXEC && SKIP_TAKEN)
		else $error("squash state without no-op");

	a_two_cycle: assert property (
		skip |=> state == ST_NOP ##1 state == ST_RUN)
		else $error("skip not two cycles");

	a_skip_span: assert property (
		state == ST_NOP |=> span == 2'(SKIP_CYCLES))
		else $error("skip span not two cycles");

	a_plain_span: assert property (
		is_test && !skip |=> span == 2'h1 && state == ST_RUN)
		else $error("test without skip not one cycle");

	a_skip_pulse: assert property (
		SKIP_TAKEN |=> !SKIP_TAKEN)
		else $error("skip pulse longer than a cycle");

	a_set_write: assert property (
		is_set |=> FILE_WR.en
		&& FILE_WR.data == ($past(rdv) | (8'h01 << $past(bidx)))
		&& FILE_WR.addr == $past(fadr))
		else $error("bit set write wrong");

	a_set_keep: assert property (
		is_set |=> (FILE_WR.data & ~$past(bmask)) == ($past(rdv) & ~$past(bmask)))
		else $error("bit set disturbed other bits");

	a_chain_set: assert property (
		is_set && fwd_hit |=> FILE_WR.data == ($past(FILE_WR.data) | $past(bmask)))
		else $error("chained bit set lost a bit");

	a_set_one: assert property (
		is_set |=> !SKIP_TAKEN && !NOP_EXEC)
		else $error("bit set took extra cycle");

	a_test_no_write: assert property (
		is_test |=> !FILE_WR.en)
		else $error("bit test wrote the file");

	a_other_quiet: assert property (
		is_other |=> !SKIP_TAKEN && !FILE_WR.en)
		else $error("foreign opcode acted on");

	a_hit_decode: assert property (
		DECODE_HIT |-> live && (opc == OPC_SET || opc == OPC_SKIP_CLR || opc == OPC_SKIP_SET))
		else $error("hit on foreign word");

	a_flags_kept: assert property (
		FLAGS_WE == 1'b0)
		else $error("flag write seen");

	// Main scenarios, the forwarded read included
	c_clr_skip: cover property (is_bsc && !tbit ##1 NOP_EXEC);
	c_set_skip: cover property (is_bss && tbit ##1 NOP_EXEC);
	c_set_bit:  cover property (is_set ##1 FILE_WR.en);
	c_no_skip:  cover property (is_bsc && tbit ##1 DECODE_HIT);
	c_fwd_skip: cover property (fwd_hit && skip ##1 NOP_EXEC);
endmodule : bit_ops_decode
`default_nettype wire

// ===== sim/file_model.sv
// File register array model behind the decoder
`default_nettype none
module file_model
	import bit_ops_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [ADDR_W-1:0] raddr,
	input  wire file_wr_t          wr,
	output logic      [DATA_W-1:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] mem [128];
	initial for (int i = 0; i < 128; i++) mem[i] = 8'(i);
	assign rdata = mem[raddr];
	always @(posedge clk) if (wr.en) mem[wr.addr] <= wr.data;
endmodule : file_model
`default_nettype wire

// ===== sim/test_bit_ops_decode.sv
// Bench for the bit test/skip/set decoder
`default_nettype none
module test_bit_ops_decode;
	import bit_ops_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, srst = 1, vld = 0, skp, no_operation, hit, fwe;
	logic [INSN_W-1:0] insn = '0;
	logic [DATA_W-1:0] rd;
	logic [ADDR_W-1:0] ra;
	file_wr_t wr;
	int bad_count = 0, comparisons = 0;
	always #2.5 clk = ~clk;
	bit_ops_decode u_bit_ops_decode(.CLK(clk), .SRST(srst), .INSN_VALID(vld), .INSN(insn),
		.FILE_RDATA(rd), .FILE_RADDR(ra), .FILE_WR(wr), .SKIP_TAKEN(skp),
		.NOP_EXEC(no_operation), .DECODE_HIT(hit), .FLAGS_WE(fwe));
	file_model u_file_model(.clk(clk), .raddr(ra), .wr(wr), .rdata(rd));
	////////////////////////////////////////////////////////////////
	task chk(string n, logic [15:0] e, logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// Outputs of the previous word settle 1 ns after the edge
	task put(logic [3:0] o, logic [2:0] b, logic [6:0] f);
		@(posedge clk);
		insn <= {o, b, f};
		vld <= 1'b1;
		#1;
	endtask : put
	task t_skip(logic [3:0] o, logic [2:0] b, logic s);
		put(o, b, 7'h01);
		chk("hit", 1, hit);
		put(OPC_SET, 3'h0, 7'h10);
		chk("skip", s, skp);
		chk("nop", s, no_operation);
		chk("hit", !s, hit);
		put(4'h0, 3'h0, 7'h00);
		chk("wr_en", !s, wr.en);
		chk("skip", 0, skp);
	endtask : t_skip
	task t_set();
		put(OPC_SET, 3'h7, 7'h05);
		put(4'h0, 3'h0, 7'h00);
		chk("wr", {1'b1, 7'h05, 8'h85}, wr);
		chk("flags", 0, fwe);
	endtask : t_set
	// Set then test the same register back to back: the pending write must be seen
	task t_rmw();
		put(OPC_SET, 3'h2, 7'h03);
		put(OPC_SKIP_SET, 3'h2, 7'h03);
		chk("wr", {1'b1, 7'h03, 8'h07}, wr);
		chk("hit", 1, hit);
		put(OPC_SET, 3'h6, 7'h03);
		chk("skip", 1, skp);
		chk("nop", 1, no_operation);
		put(4'h0, 3'h0, 7'h00);
		chk("wr_en", 0, wr.en);
	endtask : t_rmw
	task wrap_up();
		$display("checks %0d bad %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	initial begin
		#5000;
		bad_count++;
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_skip(OPC_SKIP_CLR, 3'h1, 1'b1);
		t_skip(OPC_SKIP_CLR, 3'h0, 1'b0);
		t_skip(OPC_SKIP_SET, 3'h0, 1'b1);
		t_skip(OPC_SKIP_SET, 3'h1, 1'b0);
		t_set();
		t_rmw();
		wrap_up();
	end
endmodule : test_bit_ops_decode
`default_nettype wire
